// file: design/ioo_pkg.sv
// Package with types and constants for the peripheral access ordering block
package ioo_pkg;

	localparam int IOO_ADDR_W = 32;
	localparam int IOO_DATA_W = 32;
	localparam int IOO_WB_DEPTH = 4;
	localparam int IOO_WB_IDX_W = 2;
	localparam int IOO_CNT_W = 3;
	localparam logic [IOO_CNT_W-1:0] IOO_CNT_RESET = 3'h0;
	localparam logic [IOO_CNT_W-1:0] IOO_CNT_FULL = 3'h4;

	// Kind of access presented by the pipeline
	typedef enum logic [2:0] {
		IOO_OP_MEM_RD,
		IOO_OP_MEM_WR,
		IOO_OP_PORT_RD,
		IOO_OP_PORT_WR,
		IOO_OP_SERIAL
	} ioo_op_t;

	// One access from the pipeline
	typedef struct packed {
		ioo_op_t op;
		logic cacheable;
		logic [IOO_ADDR_W-1:0] addr;
		logic [IOO_DATA_W-1:0] data;
	} ioo_req_t;

	// One transaction on the external bus
	typedef struct packed {
		logic is_write;
		logic is_port;
		logic [IOO_ADDR_W-1:0] addr;
		logic [IOO_DATA_W-1:0] data;
	} ioo_bus_t;

	localparam ioo_bus_t IOO_BUS_RESET = '0;

endpackage : ioo_pkg

// file: design/ioo_store_buf.sv
// Write buffer for memory stores awaiting the external bus
`timescale 1ns/100ps
`default_nettype none
module ioo_store_buf
	import ioo_pkg::*;
(
	input wire logic clk,
	input wire logic resetn,
	input wire logic push,
	input wire ioo_bus_t push_data,
	input wire logic pop,
	output logic full,
	output logic empty,
	output ioo_bus_t head
);

	ioo_bus_t mem_reg [IOO_WB_DEPTH];
	ioo_bus_t mem_next [IOO_WB_DEPTH];
	logic [IOO_WB_IDX_W-1:0] wr_reg, wr_next, rd_reg, rd_next;
	logic [IOO_CNT_W-1:0] cnt_reg, cnt_next;

	assign full = (cnt_reg == IOO_CNT_FULL);
	assign empty = (cnt_reg == IOO_CNT_RESET);
	assign head = mem_reg[rd_reg];

	// Pointer and count update
	always_comb begin
		wr_next = wr_reg;
		rd_next = rd_reg;
		cnt_next = cnt_reg;
		if (push && !full) begin
			wr_next = wr_reg + 2'h1;
		end
		if (pop && !empty) begin
			rd_next = rd_reg + 2'h1;
		end
		if ((push && !full) && !(pop && !empty)) begin
			cnt_next = cnt_reg + 3'h1;
		end else if (!(push && !full) && (pop && !empty)) begin
			cnt_next = cnt_reg - 3'h1;
		end
	end

	// Storage entries, one per slot
	genvar gi;
	generate
		for (gi = 0; gi < IOO_WB_DEPTH; gi++) begin : g_ent
			always_comb begin
				mem_next[gi] = mem_reg[gi];
				if (push && !full && (wr_reg == IOO_WB_IDX_W'(gi))) begin
					mem_next[gi] = push_data;
				end
			end
			always_ff @(posedge clk or negedge resetn) begin
				if (!resetn) begin
					mem_reg[gi] <= IOO_BUS_RESET;
				end else begin
					mem_reg[gi] <= mem_next[gi];
				end
			end
		end
	endgenerate

	// Register pointers
	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			wr_reg <= 2'h0;
			rd_reg <= 2'h0;
			cnt_reg <= IOO_CNT_RESET;
		end else begin
			wr_reg <= wr_next;
			rd_reg <= rd_next;
			cnt_reg <= cnt_next;
		end
	end

endmodule : ioo_store_buf
`default_nettype wire

// file: design/ioo_order.sv
// Ordering and serialisation of memory and port accesses toward the external bus
//
// What this block does
// - A cacheable read that hits the cache may complete while earlier writes still wait in the write buffer.
// - Uncacheable reads and writes reach the external bus strictly in program order.
// - A serialising instruction waits for all earlier accesses to finish before any later one is taken.
// - Port writes bypass the write buffer and go straight to the bus, keeping port accesses ordered.
// - A port read (single or string) is held until every pending store has completed on the bus.
// - After a port write (single or string) the next instruction stalls until all stores, its own too, complete.
`timescale 1ns/100ps
`default_nettype none
module ioo_order
	import ioo_pkg::*;
(
	input wire logic clk,
	input wire logic resetn,
	input wire logic req_valid,
	output logic req_ready,
	input wire ioo_req_t req,
	input wire logic cache_hit,
	input wire logic [IOO_DATA_W-1:0] cache_data,
	output logic rsp_valid,
	output logic [IOO_DATA_W-1:0] rsp_data,
	output logic bus_valid,
	input wire logic bus_ready,
	output ioo_bus_t bus_out,
	input wire logic bus_ack,
	input wire logic [IOO_DATA_W-1:0] bus_rdata,
	output logic serial_busy
);

	// Controller states
	typedef enum logic [2:0] {
		IOO_ST_IDLE,
		IOO_ST_DRAIN,
		IOO_ST_ISSUE,
		IOO_ST_WAIT_ACK,
		IOO_ST_POST_DRAIN
	} ioo_state_t;

	ioo_state_t state_reg, state_next;
	ioo_req_t hold_reg, hold_next;
	logic rsp_valid_reg, rsp_valid_next;
	logic [IOO_DATA_W-1:0] rsp_data_reg, rsp_data_next;
	logic busy_bus_reg, busy_bus_next;
	logic buf_is_head_reg, buf_is_head_next;
	logic [IOO_CNT_W-1:0] out_cnt_reg, out_cnt_next;

	logic wb_push, wb_pop, wb_full, wb_empty;
	ioo_bus_t wb_head, wb_push_data, direct_bus;
	logic direct_want, fast_hit, fast_wr, all_done;

	////////////////////////////////////////////////////////////////////////////
	// Write buffer for cacheable memory stores
	ioo_store_buf u_store_buf (
		.clk(clk),
		.resetn(resetn),
		.push(wb_push),
		.push_data(wb_push_data),
		.pop(wb_pop),
		.full(wb_full),
		.empty(wb_empty),
		.head(wb_head)
	);

	assign wb_push_data = '{is_write: 1'b1, is_port: 1'b0, addr: req.addr, data: req.data};

	// Fast paths taken straight from idle
	assign fast_hit = req_valid && (req.op == IOO_OP_MEM_RD) && req.cacheable && cache_hit;
	assign fast_wr = req_valid && (req.op == IOO_OP_MEM_WR) && req.cacheable && !wb_full;
	assign wb_push = (state_reg == IOO_ST_IDLE) && fast_wr;

	// All stores issued so far are acknowledged and none are buffered
	assign all_done = wb_empty && (out_cnt_reg == IOO_CNT_RESET) && !busy_bus_reg;

	// The held access that goes direct to the bus
	assign direct_want = (state_reg == IOO_ST_ISSUE) && (hold_reg.op != IOO_OP_SERIAL);
	assign direct_bus.is_write = (hold_reg.op == IOO_OP_MEM_WR) || (hold_reg.op == IOO_OP_PORT_WR);
	assign direct_bus.is_port = (hold_reg.op == IOO_OP_PORT_RD) || (hold_reg.op == IOO_OP_PORT_WR);
	assign direct_bus.addr = hold_reg.addr;
	assign direct_bus.data = hold_reg.data;

	////////////////////////////////////////////////////////////////////////////
	// Bus arbitration: one transaction in flight at a time keeps bus order
	always_comb begin
		bus_valid = 1'b0;
		bus_out = wb_head;
		wb_pop = 1'b0;
		busy_bus_next = busy_bus_reg;
		buf_is_head_next = buf_is_head_reg;
		out_cnt_next = out_cnt_reg;
		if (busy_bus_reg) begin
			if (bus_ack) begin
				busy_bus_next = 1'b0;
				if (buf_is_head_reg) begin
					out_cnt_next = out_cnt_reg - 3'h1;
				end
			end
		end else if (!wb_empty) begin
			// Buffered stores leave first, so direct accesses never pass them
			bus_valid = 1'b1;
			if (bus_ready) begin
				wb_pop = 1'b1;
				busy_bus_next = 1'b1;
				buf_is_head_next = 1'b1;
				out_cnt_next = out_cnt_reg + 3'h1;
			end
		end else if (direct_want && all_done) begin
			bus_valid = 1'b1;
			bus_out = direct_bus;
			if (bus_ready) begin
				busy_bus_next = 1'b1;
				buf_is_head_next = 1'b0;
			end
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// Pipeline sequencing
	always_comb begin
		state_next = state_reg;
		hold_next = hold_reg;
		rsp_valid_next = 1'b0;
		rsp_data_next = rsp_data_reg;
		req_ready = 1'b0;
		unique case (state_reg)
			IOO_ST_IDLE: begin
				if (fast_hit) begin
					req_ready = 1'b1;
					rsp_valid_next = 1'b1;
					rsp_data_next = cache_data;
				end else if (fast_wr) begin
					req_ready = 1'b1;
					rsp_valid_next = 1'b1;
				end else if (req_valid && !(req.op == IOO_OP_MEM_WR && req.cacheable)) begin
					req_ready = 1'b1;
					hold_next = req;
					if (req.op == IOO_OP_SERIAL || req.op == IOO_OP_PORT_RD) begin
						state_next = IOO_ST_DRAIN;
					end else begin
						state_next = IOO_ST_ISSUE;
					end
				end
			end
			IOO_ST_DRAIN: begin
				if (all_done) begin
					state_next = IOO_ST_ISSUE;
				end
			end
			IOO_ST_ISSUE: begin
				if (hold_reg.op == IOO_OP_SERIAL) begin
					rsp_valid_next = 1'b1;
					state_next = IOO_ST_IDLE;
				end else if (bus_valid && bus_ready && !buf_is_head_next) begin
					state_next = IOO_ST_WAIT_ACK;
				end
			end
			IOO_ST_WAIT_ACK: begin
				if (bus_ack) begin
					rsp_data_next = bus_rdata;
					if (hold_reg.op == IOO_OP_PORT_WR) begin
						state_next = IOO_ST_POST_DRAIN;
					end else begin
						rsp_valid_next = 1'b1;
						state_next = IOO_ST_IDLE;
					end
				end
			end
			IOO_ST_POST_DRAIN: begin
				if (all_done) begin
					rsp_valid_next = 1'b1;
					state_next = IOO_ST_IDLE;
				end
			end
			default: begin
				state_next = IOO_ST_IDLE;
			end
		endcase
	end

	assign rsp_valid = rsp_valid_reg;
	assign rsp_data = rsp_data_reg;
	assign serial_busy = (state_reg != IOO_ST_IDLE);

	// Register sequencing and bus state
	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			state_reg <= IOO_ST_IDLE;
			hold_reg <= '0;
			rsp_valid_reg <= 1'b0;
			rsp_data_reg <= '0;
			busy_bus_reg <= 1'b0;
			buf_is_head_reg <= 1'b0;
			out_cnt_reg <= IOO_CNT_RESET;
		end else begin
			state_reg <= state_next;
			hold_reg <= hold_next;
			rsp_valid_reg <= rsp_valid_next;
			rsp_data_reg <= rsp_data_next;
			busy_bus_reg <= busy_bus_next;
			buf_is_head_reg <= buf_is_head_next;
			out_cnt_reg <= out_cnt_next;
		end
	end

endmodule : ioo_order
`default_nettype wire

// file: verif/ioo_order_checker.sv
// Assertion checker for the access ordering block
`timescale 1ns/100ps
`default_nettype none
module ioo_order_checker
	import ioo_pkg::*;
(
	input wire logic clk,
	input wire logic resetn,
	input wire logic req_valid,
	input wire logic req_ready,
	input wire ioo_req_t req,
	input wire logic cache_hit,
	input wire logic [IOO_DATA_W-1:0] cache_data,
	input wire logic rsp_valid,
	input wire logic [IOO_DATA_W-1:0] rsp_data,
	input wire logic bus_valid,
	input wire logic bus_ready,
	input wire ioo_bus_t bus_out,
	input wire logic bus_ack,
	input wire logic serial_busy
);
	logic take, out_reg, drn_reg;
	assign take = req_valid && req_ready;
	// Outstanding bus cycle, and an instruction that must drain first
	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			out_reg <= 1'b0;
			drn_reg <= 1'b0;
		end else begin
			out_reg <= (bus_valid && bus_ready) || (out_reg && !bus_ack);
			drn_reg <= (take && req.op inside {IOO_OP_PORT_RD, IOO_OP_PORT_WR, IOO_OP_SERIAL}) || (drn_reg && !rsp_valid);
		end
	end
	default clocking @(posedge clk); endclocking
	default disable iff (!resetn);
	sequence s_hit;
		take && req.op == IOO_OP_MEM_RD && req.cacheable && cache_hit;
	endsequence
	sequence s_direct;
		take && !bus_valid && !out_reg && (req.op == IOO_OP_PORT_WR || (req.op == IOO_OP_MEM_WR && !req.cacheable));
	endsequence
	property p_hit; s_hit |=> rsp_valid && rsp_data == $past(cache_data); endproperty
	a_hit: assert property (p_hit) else $error("hit read answer");
	property p_nobus; s_hit ##0 !bus_valid && !out_reg |=> !bus_valid; endproperty
	a_nobus: assert property (p_nobus) else $error("hit read used bus");
	property p_one; bus_valid |-> !out_reg; endproperty
	a_one: assert property (p_one) else $error("bus cycle overlap");
	property p_hold; bus_valid && !bus_ready |=> bus_valid && $stable(bus_out); endproperty
	a_hold: assert property (p_hold) else $error("bus request changed");
	property p_direct; s_direct |=> bus_valid && bus_out.is_write && bus_out.addr == $past(req.addr); endproperty
	a_direct: assert property (p_direct) else $error("direct write not issued");
	property p_late; take && req.op inside {IOO_OP_PORT_RD, IOO_OP_PORT_WR} |=> !rsp_valid [*2]; endproperty
	a_late: assert property (p_late) else $error("port access answered early");
	property p_drain; drn_reg && rsp_valid |-> !out_reg && !bus_valid; endproperty
	a_drain: assert property (p_drain) else $error("done before drain");
	property p_busy; serial_busy |-> !req_ready; endproperty
	a_busy: assert property (p_busy) else $error("taken while busy");
endmodule : ioo_order_checker
bind ioo_order ioo_order_checker i_chk (.clk, .resetn, .req_valid, .req_ready, .req, .cache_hit, .cache_data,
	.rsp_valid, .rsp_data, .bus_valid, .bus_ready, .bus_out, .bus_ack, .serial_busy);
`default_nettype wire

// file: verif/ioo_bus_model.sv
// Behavioural model of the external bus controller
`timescale 1ns/100ps
`default_nettype none
module ioo_bus_model
	import ioo_pkg::*;
(
	input wire logic clk,
	input wire logic resetn,
	input wire logic slow,
	input wire logic bus_valid,
	input wire ioo_bus_t bus_out,
	output logic bus_ready,
	output logic bus_ack,
	output logic [IOO_DATA_W-1:0] bus_rdata
);
	logic busy, gap;
	logic [2:0] wait_cnt;
	logic [IOO_ADDR_W-1:0] addr_reg;
	// A slow bus also refuses every other cycle, so requests must hold while not ready
	assign bus_ready = !busy && !gap;
	// One cycle at a time; ack after a wait, read data is the inverted address
	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			busy <= 1'b0;
			gap <= 1'b0;
			wait_cnt <= 3'h0;
			addr_reg <= '0;
			bus_ack <= 1'b0;
			bus_rdata <= '0;
		end else begin
			gap <= slow && !gap;
			bus_ack <= 1'b0;
			bus_rdata <= ~bus_rdata; // Data not held outside the ack cycle
			if (busy && wait_cnt == 3'h0) begin
				busy <= 1'b0;
				bus_ack <= 1'b1;
				bus_rdata <= ~addr_reg;
			end else if (busy) begin
				wait_cnt <= wait_cnt - 3'h1;
			end else if (bus_valid && bus_ready) begin
				busy <= 1'b1;
				wait_cnt <= slow ? 3'h5 : 3'h0;
				addr_reg <= bus_out.addr;
			end
		end
	end
endmodule : ioo_bus_model
`default_nettype wire

// file: verif/tb_ioo_order.sv
// Self-checking testbench for the access ordering block
`timescale 1ns/100ps
`default_nettype none
module tb_ioo_order
	import ioo_pkg::*;
;
	typedef struct packed {ioo_op_t op; logic c; logic h; logic [31:0] a; logic [31:0] e;} ioo_row_t;
	logic clk, resetn, req_valid, req_ready, cache_hit, rsp_valid, bus_valid, bus_ready, bus_ack, serial_busy, slow;
	logic [31:0] cache_data, rsp_data, bus_rdata;
	ioo_req_t req;
	ioo_bus_t bus_out;
	int failures, n_checks;
	logic [31:0] log_q[$];
	logic [31:0] exp_q[$];
	ioo_row_t rows[9] = '{
		'{IOO_OP_MEM_RD, 1'b0, 1'b0, 32'h10, ~32'h10},
		'{IOO_OP_MEM_WR, 1'b1, 1'b0, 32'h20, ~32'h10},
		'{IOO_OP_MEM_RD, 1'b1, 1'b1, 32'h5A, 32'h5A},
		'{IOO_OP_PORT_WR, 1'b0, 1'b0, 32'h30, ~32'h30},
		'{IOO_OP_PORT_RD, 1'b0, 1'b0, 32'h40, ~32'h40},
		'{IOO_OP_SERIAL, 1'b0, 1'b0, 32'h0, ~32'h40},
		'{IOO_OP_PORT_WR, 1'b0, 1'b0, 32'h48, ~32'h48},
		'{IOO_OP_MEM_WR, 1'b0, 1'b0, 32'h50, ~32'h50},
		'{IOO_OP_MEM_RD, 1'b1, 1'b0, 32'h60, ~32'h60}};
	ioo_order i_dut (.clk, .resetn, .req_valid, .req_ready, .req, .cache_hit, .cache_data, .rsp_valid, .rsp_data,
		.bus_valid, .bus_ready, .bus_out, .bus_ack, .bus_rdata, .serial_busy);
	ioo_bus_model i_bus (.clk, .resetn, .slow, .bus_valid, .bus_out, .bus_ready, .bus_ack, .bus_rdata);
	////////////////////////////////////////
	// Clock and log of accepted bus cycles
	initial begin
		clk = 1'b0;
		forever #5 clk = ~clk;
	end
	always @(posedge clk) begin
		if (bus_valid && bus_ready) log_q.push_back({bus_out.is_port, bus_out.is_write, bus_out.addr[29:0]});
	end
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		n_checks++;
		if (got !== exp) begin
			failures++;
			$display("mismatch t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask : chk
	task automatic complete_run;
		$display("checks=%0d failures=%0d", n_checks, failures);
		if (failures == 0 && n_checks > 0) $display("TEST PASSED");
		else $display("TEST FAILED");
		$finish;
	endtask : complete_run
	// Offer one access at the falling edge, wait for take and answer
	task automatic run_op(input ioo_row_t r);
		int i;
		req_valid = 1'b1;
		req = '{r.op, r.c, r.a, r.a};
		cache_hit = r.h;
		cache_data = r.a;
		// Let the ready decode settle, then hold the request through exactly one taking edge
		#1;
		for (i = 0; i < 300 && !req_ready; i++) begin
			@(negedge clk);
			#1;
		end
		@(negedge clk);
		req_valid = 1'b0;
		if (i == 300) begin
			failures++;
			complete_run();
		end
		for (i = 0; i < 300 && !rsp_valid; i++) @(negedge clk);
		if (i == 300) begin
			failures++;
			complete_run();
		end
		chk(rsp_data, r.e);
		chk({31'h0, serial_busy}, 32'h0);
	endtask : run_op
	////////////////////////////////////////
	// Table pass with a prompt then a slow bus, then reset in mid-run
	initial begin
		resetn = 1'b0;
		req_valid = 1'b0;
		req = '0;
		cache_hit = 1'b0;
		cache_data = '0;
		slow = 1'b0;
		failures = 0;
		n_checks = 0;
		repeat (5) @(negedge clk);
		resetn = 1'b1;
		for (int s = 0; s < 2; s++) begin
			slow = s[0];
			log_q.delete();
			exp_q.delete();
			foreach (rows[k]) begin
				run_op(rows[k]);
				if (!rows[k].h && rows[k].op != IOO_OP_SERIAL) begin
					exp_q.push_back({(rows[k].op inside {IOO_OP_PORT_RD, IOO_OP_PORT_WR}),
						(rows[k].op inside {IOO_OP_MEM_WR, IOO_OP_PORT_WR}), rows[k].a[29:0]});
				end
			end
			chk(32'(log_q.size()), 32'(exp_q.size()));
			foreach (exp_q[k]) chk(log_q[k], exp_q[k]);
		end
		// Six buffered writes on the slow bus overfill the buffer, then a serialising step drains it
		log_q.delete();
		for (int k = 0; k < 6; k++) run_op('{IOO_OP_MEM_WR, 1'b1, 1'b0, 32'(32'h80 + k), ~32'h60});
		run_op('{IOO_OP_SERIAL, 1'b0, 1'b0, 32'h0, ~32'h60});
		chk(32'(log_q.size()), 32'h6);
		foreach (log_q[k]) chk(log_q[k], {2'b01, 30'(32'h80 + k)});
		req_valid = 1'b1;
		req = '{IOO_OP_PORT_WR, 1'b0, 32'h70, 32'h70};
		repeat (3) @(negedge clk);
		resetn = 1'b0;
		req_valid = 1'b0;
		@(negedge clk);
		chk({29'h0, bus_valid, rsp_valid, serial_busy}, 32'h0);
		resetn = 1'b1;
		run_op(rows[2]);
		complete_run();
	end
endmodule : tb_ioo_order
`default_nettype wire
